// file: hw/conv_mode_pkg.sv
// Operation
// - In the default all-zero mode the block converts without pause and stores every result.
// - The ready output goes low whenever a finished result lands in the data register.
// - The host turns on continuous readout with a one in the continuous-read bit, after which clocking reads results.
// - With continuous readout on, results are shifted out on serial clock pulses with no read command; one arriving at a full buffer is dropped.
// - After reset or any reconfiguration the first result waits the full settling time, later ones follow at the update rate.
// - Single mode powers up, waits 1 ms for the oscillator, then runs one full-settling conversion.
// - At the end of a single conversion the result is stored, ready goes low and the block powers down by itself.
// - After a single conversion the result and the low ready level stay until the data is read or a new conversion starts.
// - Idle mode holds filter and modulator in reset while the modulator clock keeps running.
// - Power-down mode stops everything except the sensor power switch and the crystal oscillator.
package conv_mode_pkg;
    localparam int DATA_W = 24;
    localparam logic [2:0] MODE_CONT = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h2;
    localparam logic [2:0] MODE_PDOWN = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam int CLK_MHZ = 100;
    localparam int OSC_SETTLE_MS = 1;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * 1000 * 1000 * CLK_MHZ / 1000;
    localparam int CONV_CYC_DEF = 20000;
    localparam int SETTLE_FACTOR = 2;
    localparam int MOD_DIV = 16;
    localparam int CNT_W = 24;

    typedef struct packed {
        logic [2:0] mode;
        logic mode_wr;
    } mode_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } result_t;
endpackage

// file: hw/conv_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module conv_mode_ctrl #(
    parameter int OSC_CYC = conv_mode_pkg::OSC_SETTLE_CYC,
    parameter int CONV_CYC = conv_mode_pkg::CONV_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire conv_mode_pkg::mode_cmd_t cmd,
    input wire logic continuous_read_enable,
    input wire logic read_cmd,
    input wire logic [conv_mode_pkg::DATA_W-1:0] sample_in,
    input wire logic sclk_pin,
    output logic dout,
    output logic ready_n,
    output logic [conv_mode_pkg::DATA_W-1:0] data_reg,
    output logic filter_rst,
    output logic mod_clk_en,
    output logic powered,
    output logic sensor_switch_on,
    output logic [2:0] mode_reg
);
    typedef enum logic [2:0] {ST_PDOWN, ST_OSC, ST_SETTLE, ST_RUN, ST_IDLE} state_t;
    localparam int SETTLE_CYC = CONV_CYC * conv_mode_pkg::SETTLE_FACTOR;
    localparam int DW = conv_mode_pkg::DATA_W;

    state_t state_reg, state_next;
    logic [conv_mode_pkg::CNT_W-1:0] cnt_reg;
    logic [3:0] div_reg;
    logic sclk_s1, sclk_s2, sclk_s3;
    // Two-entry result buffer
    logic [DW-1:0] buf_mem [2];
    logic wr_ptr, rd_ptr;
    logic [1:0] fill;
    logic [DW-1:0] shreg;
    logic [5:0] bits_left;
    logic armed_reg;

    wire mode_change = cmd.mode_wr && (cmd.mode != mode_reg);
    wire [2:0] new_mode = cmd.mode_wr ? cmd.mode : mode_reg;
    wire conv_done = (state_reg == ST_SETTLE || state_reg == ST_RUN)
        && cnt_reg == '0 && !mode_change;
    wire buf_in_ready = (fill != 2'd2);
    wire buf_in_valid = conv_done;
    wire buf_out_valid = (fill != 2'd0);
    wire sclk_fall = !sclk_s2 && sclk_s3;
    wire shifting = (bits_left != 6'd0);
    wire may_load = continuous_read_enable || armed_reg;
    wire buf_out_ready = !shifting && may_load;
    wire pop = buf_out_valid && buf_out_ready;
    wire push = buf_in_valid && buf_in_ready;
    wire [conv_mode_pkg::CNT_W-1:0] settle_load = conv_mode_pkg::CNT_W'(SETTLE_CYC - 1);
    wire [conv_mode_pkg::CNT_W-1:0] conv_load = conv_mode_pkg::CNT_W'(CONV_CYC - 1);
    wire [conv_mode_pkg::CNT_W-1:0] osc_load = conv_mode_pkg::CNT_W'(OSC_CYC - 1);

    function automatic state_t entry_state(input logic [2:0] m);
        case (m)
            conv_mode_pkg::MODE_CONT: entry_state = ST_SETTLE;
            conv_mode_pkg::MODE_SINGLE: entry_state = ST_OSC;
            conv_mode_pkg::MODE_IDLE: entry_state = ST_IDLE;
            default: entry_state = ST_PDOWN;
        endcase
    endfunction

    always_comb
    begin
        state_next = state_reg;
        if (mode_change)
            state_next = entry_state(cmd.mode);
        else
            unique case (state_reg)
                ST_PDOWN: state_next = ST_PDOWN;
                ST_IDLE: state_next = ST_IDLE;
                ST_OSC: if (cnt_reg == '0) state_next = ST_SETTLE;
                ST_SETTLE:
                    if (cnt_reg == '0)
                        state_next = (mode_reg == conv_mode_pkg::MODE_SINGLE) ? ST_PDOWN
                            : ST_RUN;
                ST_RUN: state_next = ST_RUN;
            endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_SETTLE;
            cnt_reg <= conv_mode_pkg::CNT_W'(SETTLE_CYC - 1);
            mode_reg <= conv_mode_pkg::MODE_RESET;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= new_mode;
            if (state_next != state_reg || mode_change)
                // Settling only before the first result, update rate after it
                cnt_reg <= (state_next == ST_OSC) ? osc_load
                    : (state_next == ST_RUN) ? conv_load : settle_load;
            else if (state_reg == ST_RUN && cnt_reg == '0)
                cnt_reg <= conv_load;
            else if (cnt_reg != '0)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Modulator clock enable keeps running in idle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            div_reg <= 4'h0;
            mod_clk_en <= 1'b0;
        end
        else
        begin
            div_reg <= div_reg + 1'b1;
            mod_clk_en <= (div_reg == 4'(conv_mode_pkg::MOD_DIV - 1))
                && state_reg != ST_PDOWN;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            filter_rst <= 1'b1;
            powered <= 1'b0;
            sensor_switch_on <= 1'b0;
        end
        else
        begin
            filter_rst <= state_next == ST_IDLE || state_next == ST_PDOWN
                || state_next == ST_OSC || mode_change;
            powered <= state_next != ST_PDOWN;
            sensor_switch_on <= 1'b1;
        end
    end

    // Latest result register and ready flag
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            data_reg <= '0;
            ready_n <= 1'b1;
        end
        else
        begin
            if (conv_done)
                data_reg <= sample_in;
            if (conv_done)
                ready_n <= 1'b0;
            else if (pop || (state_reg == ST_OSC && cnt_reg == '0))
                ready_n <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
        end
        else
        begin
            sclk_s1 <= sclk_pin;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                buf_mem[wr_ptr] <= sample_in;
                wr_ptr <= !wr_ptr;
            end
            if (pop)
                rd_ptr <= !rd_ptr;
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end

    // Serial shifter: MSB first, new bit after each falling edge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            shreg <= '0;
            bits_left <= 6'd0;
            armed_reg <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            if (pop)
            begin
                shreg <= buf_mem[rd_ptr];
                bits_left <= 6'(DW);
                armed_reg <= 1'b0;
                dout <= buf_mem[rd_ptr][DW-1];
            end
            else
            begin
                if (read_cmd)
                    armed_reg <= 1'b1;
                if (shifting && sclk_fall)
                begin
                    shreg <= {shreg[DW-2:0], 1'b0};
                    bits_left <= bits_left - 1'b1;
                    dout <= shreg[DW-2];
                end
                else if (!shifting)
                    dout <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// file: test/conv_mode_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module conv_mode_ctrl_properties #(
    parameter int OSC_CYC = 20,
    parameter int CONV_CYC = 10
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire conv_mode_pkg::mode_cmd_t cmd,
    input wire logic continuous_read_enable,
    input wire logic read_cmd,
    input wire logic [conv_mode_pkg::DATA_W-1:0] sample_in,
    input wire logic ready_n,
    input wire logic [conv_mode_pkg::DATA_W-1:0] data_reg,
    input wire logic filter_rst,
    input wire logic mod_clk_en,
    input wire logic powered,
    input wire logic sensor_switch_on,
    input wire logic [2:0] mode_reg
);
    localparam int LAT_LO = OSC_CYC + 2 * CONV_CYC - 1;
    localparam int LAT_HI = LAT_LO + 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence single_start;
        cmd.mode_wr && cmd.mode == conv_mode_pkg::MODE_SINGLE
            && mode_reg != conv_mode_pkg::MODE_SINGLE;
    endsequence
    sequence single_done;
        ##[LAT_LO:LAT_HI] $fell(ready_n) ##[0:1] !powered;
    endsequence
    a_result_sets_ready: assert property (!$stable(data_reg) |-> !ready_n)
        else $error("ready_n not low on new result");
    a_result_from_input: assert property (!$stable(data_reg) |-> data_reg == $past(sample_in))
        else $error("stored result differs from sample");
    a_single_one_shot: assert property (single_start |-> single_done)
        else $error("single conversion timing wrong");
    a_ready_held_low: assert property (!ready_n && !read_cmd && !$past(read_cmd)
        && !continuous_read_enable && !cmd.mode_wr && !$past(cmd.mode_wr)
        && !(powered && filter_rst) |=> !ready_n)
        else $error("ready_n released without read");
    a_idle_filter_reset: assert property (mode_reg == conv_mode_pkg::MODE_IDLE
        && $past(mode_reg) == conv_mode_pkg::MODE_IDLE |-> filter_rst)
        else $error("filter not held in idle");
    a_idle_clock_runs: assert property (mod_clk_en && mode_reg == conv_mode_pkg::MODE_IDLE
        |-> ##16 (mod_clk_en || mode_reg != conv_mode_pkg::MODE_IDLE))
        else $error("modulator clock stopped in idle");
    a_pdown_all_off: assert property (mode_reg == conv_mode_pkg::MODE_PDOWN
        && $past(mode_reg) == conv_mode_pkg::MODE_PDOWN |-> !powered && !mod_clk_en)
        else $error("circuitry active in power-down");
    a_sensor_kept_live: assert property (!$past(sys_rst) |-> sensor_switch_on)
        else $error("sensor switch dropped");
endmodule
bind conv_mode_ctrl conv_mode_ctrl_properties #(.OSC_CYC(OSC_CYC), .CONV_CYC(CONV_CYC)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd), .read_cmd(read_cmd),
    .continuous_read_enable(continuous_read_enable), .sample_in(sample_in), .ready_n(ready_n),
    .data_reg(data_reg), .filter_rst(filter_rst), .mod_clk_en(mod_clk_en), .powered(powered),
    .sensor_switch_on(sensor_switch_on), .mode_reg(mode_reg));
`default_nettype wire

// file: test/host_serial_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
    input wire logic core_clk,
    input wire logic dout,
    input wire logic ready_n,
    output logic sclk_pin,
    output logic read_cmd,
    output logic continuous_read_enable
);
    initial
    begin
        sclk_pin = 1'b1;
        read_cmd = 1'b0;
        continuous_read_enable = 1'b0;
    end
    task automatic set_continuous_read_enable(input logic v);
        continuous_read_enable = v;
    endtask
    task automatic read_word(output logic [23:0] w);
        int n;
        n = 0;
        while (ready_n !== 1'b0 && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        if (!continuous_read_enable)
        begin
            read_cmd = 1'b1;
            @(negedge core_clk);
            read_cmd = 1'b0;
        end
        repeat (3) @(negedge core_clk);
        for (int i = 23; i >= 0; i--)
        begin
            w[i] = dout;
            sclk_pin = 1'b0;
            repeat (4) @(negedge core_clk);
            sclk_pin = 1'b1;
            repeat (4) @(negedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// file: test/tb_adc_conversion_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_conversion_mode_control;
    localparam int OSC = 20;
    localparam int CONV = 10;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    conv_mode_pkg::mode_cmd_t cmd = '0;
    logic [23:0] sample_in = 24'h0;
    logic sclk_pin, read_cmd, cre, dout, ready_n, filter_rst, mod_clk_en, powered, sensor_on;
    logic [23:0] data_reg, w;
    logic [2:0] mode_reg;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, n;
    conv_mode_ctrl #(.OSC_CYC(OSC), .CONV_CYC(CONV)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd), .continuous_read_enable(cre),
        .read_cmd(read_cmd), .sample_in(sample_in), .sclk_pin(sclk_pin), .dout(dout),
        .ready_n(ready_n), .data_reg(data_reg), .filter_rst(filter_rst), .mod_clk_en(mod_clk_en),
        .powered(powered), .sensor_switch_on(sensor_on), .mode_reg(mode_reg));
    host_serial_model u_host (.core_clk(core_clk), .dout(dout), .ready_n(ready_n),
        .sclk_pin(sclk_pin), .read_cmd(read_cmd), .continuous_read_enable(cre));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_mode(logic [2:0] m);
        cmd = '{mode: m, mode_wr: 1'b1};
        @(negedge core_clk);
        cmd.mode_wr = 1'b0;
    endtask
    task automatic wait_rdy();
        t0 = cyc;
        while (ready_n !== 1'b0 && cyc - t0 < 200) @(negedge core_clk);
    endtask
    task automatic pulses(int len);
        n = 0;
        repeat (len)
        begin
            @(negedge core_clk);
            n += int'(mod_clk_en);
        end
    endtask
    task automatic t_cont();
        sample_in = 24'ha5c3e1;
        wait_rdy();
        chk("first_lat", 24'h1, 24'(cyc - t0 >= 2 * CONV - 1 && cyc - t0 <= 2 * CONV + 3));
        chk("first_data", 24'ha5c3e1, data_reg);
        sample_in = 24'h3c5a96;
        repeat (CONV + 3) @(negedge core_clk);
        sample_in = 24'h0f0f0f;
        repeat (2 * CONV) @(negedge core_clk);
        u_host.read_word(w);
        chk("buf_first", 24'ha5c3e1, w);
        u_host.read_word(w);
        chk("buf_second", 24'h3c5a96, w);
    endtask
    task automatic t_single();
        sample_in = 24'h5a0ff0;
        wr_mode(conv_mode_pkg::MODE_SINGLE);
        @(negedge core_clk);
        n = cyc;
        while (ready_n !== 1'b1 && cyc - n < 100) @(negedge core_clk);
        wait_rdy();
        chk("single_lat", 24'h1, 24'(cyc - n >= OSC + 2 * CONV - 3 && cyc - n <= OSC + 2 * CONV + 1));
        chk("single_data", 24'h5a0ff0, data_reg);
        @(negedge core_clk);
        chk("single_pwr", 24'h0, 24'(powered));
        repeat (30) @(negedge core_clk);
        chk("single_held", 24'h0, 24'(ready_n));
    endtask
    task automatic t_idle_pdown();
        wr_mode(conv_mode_pkg::MODE_IDLE);
        pulses(4);
        chk("idle_rst", 24'h1, 24'(filter_rst));
        pulses(32);
        chk("idle_clk", 24'h2, 24'(n));
        wr_mode(conv_mode_pkg::MODE_PDOWN);
        pulses(4);
        pulses(32);
        chk("pdown_clk", 24'h0, 24'(n));
        chk("pdown_pwr", 24'h1, 24'({powered, sensor_on}));
        chk("pdown_mode", 24'h3, 24'(mode_reg));
    endtask
    task automatic t_continuous_read_enable();
        sys_rst = 1'b1;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        sample_in = 24'h96e187;
        u_host.set_continuous_read_enable(1'b1);
        u_host.read_word(w);
        chk("continuous_read_enable_word", 24'h96e187, w);
    endtask
    initial
    begin
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        t_cont();
        t_single();
        t_idle_pdown();
        t_continuous_read_enable();
        end_of_test();
    end
endmodule
`default_nettype wire
